// ===== pll_loop_config_registers.sv
// Purpose: Loop configuration words and their analog decode
// Assumes: Serial interface logic delivers address, write strobe and data
// Notes: Codes outside the listed sets flag as not valid
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Source current code bits 15-10, reset 14h
// - Sink current code bits 9-4, same mapping
// - Prescaler B bits 3-2, divides 4 to 6
// - Prescaler A bits 1-0, divides 4 to 6
// - Zero capacitor bits 13-9, 30 pF steps
// - Zero resistor bits 8-5, zero means open
// - Pole capacitor bits 4-0, half-pF offset
// - Filter word at 1Fh, reset 1E72h
// - Pump word at 1Eh, reset 5140h
module pll_loop_config_registers (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Register access from serial interface
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  output logic [15:0] O_REG_RDATA,
  output logic O_REG_HIT,
  // Raw field codes
  output pll_cfg_pkg::pump_word_t O_PUMP_WORD,
  output pll_cfg_pkg::filter_word_t O_FILTER_WORD,
  // Decoded settings
  output pll_cfg_pkg::analog_setting_t O_SETTING
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] pump_value;
  logic [15:0] filter_value;
  logic pump_sel;
  logic filter_sel;

  // Word address compare shared by both selects
  function automatic logic addr_match(input logic [7:0] addr,
                                      input logic [7:0] target);
    logic match;
    match = (addr == target);
    return match;
  endfunction

  assign pump_sel = addr_match(I_REG_ADDR, pll_cfg_pkg::PUMP_ADDR);
  assign filter_sel = addr_match(I_REG_ADDR, pll_cfg_pkg::FILTER_ADDR);

  pll_cfg_word #(
    .RESET_VALUE(pll_cfg_pkg::PUMP_RESET)
  ) u_pump_word (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_wr_en(I_REG_WR && pump_sel),
    .i_wr_data(I_REG_WDATA),
    .o_value(pump_value)
  );

  // Reserved bits 15-14 are stored and read back
  pll_cfg_word #(
    .RESET_VALUE(pll_cfg_pkg::FILTER_RESET)
  ) u_filter_word (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_wr_en(I_REG_WR && filter_sel),
    .i_wr_data(I_REG_WDATA),
    .o_value(filter_value)
  );

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Tenths of mA; upper band 37h..3Fh continues at 3.2 mA
  function automatic logic [6:0] pump_decode(input logic [5:0] code);
    logic [6:0] result;
    result = 7'h00;
    if (code <= pll_cfg_pkg::PUMP_LOW_LAST)
    begin
      result = {1'b1, code};
    end
    else if (code >= pll_cfg_pkg::PUMP_HIGH_FIRST)
    begin
      result = {1'b1, 6'(code - pll_cfg_pkg::PUMP_HIGH_FIRST + pll_cfg_pkg::PUMP_HIGH_BASE)};
    end
    return result;
  endfunction

  // Ratio in bit 3..1, valid in bit 0
  function automatic logic [3:0] prescale_decode(input logic [1:0] code);
    logic [3:0] result;
    result = 4'h0;
    if (code <= pll_cfg_pkg::PRESCALE_LAST)
    begin
      result = {3'(pll_cfg_pkg::PRESCALE_MIN_RATIO + {1'b0, code - pll_cfg_pkg::PRESCALE_BASE}),
                1'b1};
    end
    return result;
  endfunction

  // Half-unit offset steps used by resistor and pole capacitor
  function automatic logic [7:0] half_step(input logic [4:0] code);
    logic [7:0] result;
    result = 8'h00;
    if (code != 5'h00)
    begin
      result = 8'(code * pll_cfg_pkg::TENTHS_PER_UNIT - pll_cfg_pkg::HALF_UNIT_TENTHS);
    end
    return result;
  endfunction

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (pll_cfg_pkg::PUMP_ADDR == pll_cfg_pkg::FILTER_ADDR)
  begin : g_addr_clash
    $error("Pump and filter words need distinct addresses");
  end
  if (pll_cfg_pkg::PUMP_HIGH_FIRST <= pll_cfg_pkg::PUMP_LOW_LAST)
  begin : g_band_order
    $error("Upper current band must start above the lower band");
  end
  if (pll_cfg_pkg::PUMP_HIGH_BASE != pll_cfg_pkg::PUMP_LOW_LAST + 6'h01)
  begin : g_band_join
    $error("Upper current band must continue the lower band");
  end
  if (pll_cfg_pkg::HALF_UNIT_TENTHS >= pll_cfg_pkg::TENTHS_PER_UNIT)
  begin : g_half_step
    $error("Half step must be below one unit");
  end

  // ----------------------------------------------------------------
  // Field decode and read path
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rdata;
    logic hit;
    pll_cfg_pkg::analog_setting_t setting;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;
  pll_cfg_pkg::pump_word_t pump_w;
  pll_cfg_pkg::filter_word_t filter_w;

  assign pump_w = pump_value;
  assign filter_w = filter_value;

  always_comb
  begin
    logic [6:0] src;
    logic [6:0] snk;
    logic [3:0] psa;
    logic [3:0] psb;
    src = pump_decode(pump_w.pump_source_current_code);
    snk = pump_decode(pump_w.pump_sink_current_code);
    psb = prescale_decode(pump_w.prescale_b_code);
    psa = prescale_decode(pump_w.prescale_a_code);
    state_next = state_reg;
    state_next.setting.source_current_tenths_ma = src[5:0];
    state_next.setting.source_current_valid = src[6];
    state_next.setting.sink_current_tenths_ma = snk[5:0];
    state_next.setting.sink_current_valid = snk[6];
    state_next.setting.prescale_b_ratio = psb[3:1];
    state_next.setting.prescale_b_valid = psb[0];
    state_next.setting.prescale_a_ratio = psa[3:1];
    state_next.setting.prescale_a_valid = psa[0];
    state_next.setting.zero_cap_pf =
      10'(filter_w.filter_zero_capacitor_code * pll_cfg_pkg::ZCAP_STEP_PF);
    state_next.setting.zero_cap_valid =
      (filter_w.filter_zero_capacitor_code <= pll_cfg_pkg::ZCAP_LAST);
    state_next.setting.zero_res_tenths_kohm =
      half_step({1'b0, filter_w.filter_zero_resistor_code});
    state_next.setting.zero_res_open = (filter_w.filter_zero_resistor_code == 4'h0);
    state_next.setting.zero_res_valid =
      (filter_w.filter_zero_resistor_code <= pll_cfg_pkg::RES_LAST);
    state_next.setting.pole_cap_tenths_pf =
      half_step(filter_w.filter_pole_capacitor_code);
    state_next.setting.pole_cap_valid =
      (filter_w.filter_pole_capacitor_code <= pll_cfg_pkg::PCAP_LAST);
    state_next.hit = 1'b0;
    if (I_REG_RD)
    begin
      state_next.hit = pump_sel || filter_sel;
      if (pump_sel)
      begin
        state_next.rdata = pump_value;
      end
      else if (filter_sel)
      begin
        state_next.rdata = filter_value;
      end
      else
      begin
        state_next.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign O_REG_RDATA = state_reg.rdata;
  assign O_REG_HIT = state_reg.hit;
  assign O_PUMP_WORD = pump_w;
  assign O_FILTER_WORD = filter_w;
  assign O_SETTING = state_reg.setting;

endmodule // pll_loop_config_registers
`default_nettype wire

// ===== pll_cfg_pkg.sv
// Purpose: Constants and types for the loop configuration register pair
// Assumes: 16-bit register words, word addresses
// Notes: Currents, zero resistor and pole capacitor are decoded in tenths of units; zero capacitor in whole pF
package pll_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PUMP_ADDR = 8'h1E;
  localparam logic [7:0] FILTER_ADDR = 8'h1F;
  localparam logic [15:0] PUMP_RESET = 16'h5140;
  localparam logic [15:0] FILTER_RESET = 16'h1E72;

  // ----------------------------------------------------------------
  // Field codes and limits
  // ----------------------------------------------------------------
  localparam logic [5:0] PUMP_LOW_LAST = 6'h1F;
  localparam logic [5:0] PUMP_HIGH_FIRST = 6'h37;
  localparam logic [5:0] PUMP_HIGH_BASE = 6'h20;
  localparam logic [1:0] PRESCALE_BASE = 2'h0;
  localparam logic [1:0] PRESCALE_LAST = 2'h2;
  localparam logic [2:0] PRESCALE_MIN_RATIO = 3'h4;
  localparam logic [4:0] ZCAP_LAST = 5'h14;
  localparam logic [9:0] ZCAP_STEP_PF = 10'h01E;
  localparam logic [3:0] RES_LAST = 4'hC;
  localparam logic [4:0] PCAP_LAST = 5'h14;
  localparam logic [7:0] TENTHS_PER_UNIT = 8'h0A;
  localparam logic [7:0] HALF_UNIT_TENTHS = 8'h05;

  // ----------------------------------------------------------------
  // Word layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] pump_source_current_code;
    logic [5:0] pump_sink_current_code;
    logic [1:0] prescale_b_code;
    logic [1:0] prescale_a_code;
  } pump_word_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic [4:0] filter_zero_capacitor_code;
    logic [3:0] filter_zero_resistor_code;
    logic [4:0] filter_pole_capacitor_code;
  } filter_word_t;

  // Decoded analog view of both words
  typedef struct packed {
    logic [5:0] source_current_tenths_ma;
    logic source_current_valid;
    logic [5:0] sink_current_tenths_ma;
    logic sink_current_valid;
    logic [2:0] prescale_a_ratio;
    logic prescale_a_valid;
    logic [2:0] prescale_b_ratio;
    logic prescale_b_valid;
    logic [9:0] zero_cap_pf;
    logic zero_cap_valid;
    logic [7:0] zero_res_tenths_kohm;
    logic zero_res_open;
    logic zero_res_valid;
    logic [7:0] pole_cap_tenths_pf;
    logic pole_cap_valid;
  } analog_setting_t;

endpackage

// ===== pll_cfg_word.sv
// Purpose: One 16-bit read-write configuration word with reset value
// Assumes: Single clock, asynchronous active-high reset
// Notes: Read data is registered
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_word #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Write side
  input wire logic i_wr_en,
  input wire logic [15:0] i_wr_data,
  // Stored value
  output logic [15:0] o_value
);

  typedef struct packed {
    logic [15:0] value;
  } word_state_t;

  word_state_t state_reg;
  word_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (i_wr_en)
    begin
      state_next.value = i_wr_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg.value <= RESET_VALUE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_value = state_reg.value;

endmodule // pll_cfg_word
`default_nettype wire

// ===== pll_loop_config_registers_monitor.sv
// Purpose: Port checker for the loop configuration words
// Assumes: Async active-high reset, one clock
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_monitor (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Register access
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  input wire logic [15:0] O_REG_RDATA,
  input wire logic O_REG_HIT,
  // Words and decode
  input wire pll_cfg_pkg::pump_word_t O_PUMP_WORD,
  input wire pll_cfg_pkg::filter_word_t O_FILTER_WORD,
  input wire pll_cfg_pkg::analog_setting_t O_SETTING
);
  localparam logic [7:0] pa = pll_cfg_pkg::PUMP_ADDR;
  localparam logic [7:0] fa = pll_cfg_pkg::FILTER_ADDR;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  pump_write_a: assert property (
    I_REG_WR && I_REG_ADDR == pa |=> O_PUMP_WORD == $past(I_REG_WDATA))
    else $error("pump word not written");
  filter_write_a: assert property (
    I_REG_WR && I_REG_ADDR == fa |=> O_FILTER_WORD == $past(I_REG_WDATA))
    else $error("filter word not written");
  pump_read_a: assert property (
    I_REG_RD && I_REG_ADDR == pa |=> O_REG_HIT && O_REG_RDATA == $past(O_PUMP_WORD))
    else $error("pump read wrong");
  filter_read_a: assert property (
    I_REG_RD && I_REG_ADDR == fa |=> O_REG_HIT && O_REG_RDATA == $past(O_FILTER_WORD))
    else $error("filter read wrong");
  miss_read_a: assert property (
    I_REG_RD && I_REG_ADDR != pa && I_REG_ADDR != fa |=> !O_REG_HIT && O_REG_RDATA == 16'h0000)
    else $error("unmapped read wrong");
  low_current_a: assert property (
    O_PUMP_WORD.pump_source_current_code <= 6'h1F |=> O_SETTING.source_current_valid
    && O_SETTING.source_current_tenths_ma == $past(O_PUMP_WORD.pump_source_current_code))
    else $error("source current decode wrong");
  high_current_a: assert property (
    O_PUMP_WORD.pump_sink_current_code >= 6'h37 |=> O_SETTING.sink_current_tenths_ma
    == $past(O_PUMP_WORD.pump_sink_current_code) - 6'h17)
    else $error("sink current decode wrong");
  zero_cap_a: assert property (
    O_FILTER_WORD.filter_zero_capacitor_code <= 5'h14 |=> O_SETTING.zero_cap_pf
    == 10'h01E * $past(O_FILTER_WORD.filter_zero_capacitor_code))
    else $error("zero capacitor decode wrong");
  prescale_ratio_a: assert property (
    O_PUMP_WORD.prescale_a_code <= 2'h2 |=> O_SETTING.prescale_a_valid
    && O_SETTING.prescale_a_ratio == 3'h4 + $past(O_PUMP_WORD.prescale_a_code))
    else $error("prescaler ratio decode wrong");
endmodule // pll_cfg_monitor
bind pll_loop_config_registers pll_cfg_monitor mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR), .I_REG_WDATA(I_REG_WDATA), .I_REG_RD(I_REG_RD),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_HIT(O_REG_HIT), .O_PUMP_WORD(O_PUMP_WORD),
  .O_FILTER_WORD(O_FILTER_WORD), .O_SETTING(O_SETTING));
`default_nettype wire

// ===== test_pll_loop_config_registers.sv
// Purpose: Register and decode tests of the loop configuration words
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected values worked out by hand
`timescale 1ns/1ps
`default_nettype none
module test_pll_loop_config_registers;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic hit;
  pll_cfg_pkg::pump_word_t pw;
  pll_cfg_pkg::filter_word_t fw;
  pll_cfg_pkg::analog_setting_t st;
  logic [7:0] flags;
  assign flags = {st.zero_res_open, st.source_current_valid, st.sink_current_valid,
    st.prescale_a_valid, st.prescale_b_valid, st.zero_cap_valid, st.zero_res_valid,
    st.pole_cap_valid};
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  pll_loop_config_registers dut (.I_CLK(clk), .I_SYS_RST(rst), .I_REG_ADDR(addr),
    .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .O_REG_HIT(hit), .O_PUMP_WORD(pw), .O_FILTER_WORD(fw), .O_SETTING(st));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Access with optional same-cycle read
  task automatic acc(input logic [7:0] a, input logic w, input logic r, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr = w;
    rd = r;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input logic h);
    acc(a, 1'b0, 1'b1, 16'h0000);
    chk(rdata, exp);
    chk(16'(hit), 16'(h));
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(pw, 16'h5140);
    chk(fw, 16'h1E72);
    settle();
    chk(16'(st.source_current_tenths_ma), 16'h0014);
    chk(16'(st.sink_current_tenths_ma), 16'h0014);
    chk(16'(st.prescale_b_ratio), 16'h0004);
    chk(16'(st.prescale_a_ratio), 16'h0004);
    chk(16'(st.zero_cap_pf), 16'h01C2);
    chk(16'(st.zero_res_tenths_kohm), 16'h0019);
    chk(16'(st.pole_cap_tenths_pf), 16'h00AF);
    chk(16'(flags), 16'h007F);
    rdc(8'h1E, 16'h5140, 1'b1);
    rdc(8'h1F, 16'h1E72, 1'b1);
    rdc(8'h20, 16'h0000, 1'b0);
    acc(8'h1E, 1'b1, 1'b0, 16'hFDF6);
    settle();
    chk(16'(st.source_current_tenths_ma), 16'h0028);
    chk(16'(st.sink_current_tenths_ma), 16'h001F);
    chk(16'(st.prescale_b_ratio), 16'h0005);
    chk(16'(st.prescale_a_ratio), 16'h0006);
    acc(8'h1F, 1'b1, 1'b1, 16'hE994);
    chk(rdata, 16'h1E72);
    settle();
    chk(16'(st.zero_cap_pf), 16'h0258);
    chk(16'(st.zero_res_tenths_kohm), 16'h0073);
    chk(16'(st.pole_cap_tenths_pf), 16'h00C3);
    rdc(8'h1F, 16'hE994, 1'b1);
    acc(8'h20, 1'b1, 1'b0, 16'h0000);
    rdc(8'h1E, 16'hFDF6, 1'b1);
    acc(8'h1E, 1'b1, 1'b0, 16'hDFC9);
    settle();
    chk(16'(st.source_current_tenths_ma), 16'h0020);
    chk(16'(st.sink_current_tenths_ma), 16'h0025);
    chk(16'(st.prescale_b_ratio), 16'h0006);
    chk(16'(st.prescale_a_ratio), 16'h0005);
    chk(16'(flags), 16'h007F);
    acc(8'h1F, 1'b1, 1'b0, 16'h0000);
    settle();
    chk(16'(st.zero_res_open), 16'h0001);
    chk(16'(st.pole_cap_tenths_pf), 16'h0000);
    chk(16'(flags), 16'h00FF);
    rst = 1'b1;
    settle();
    rst = 1'b0;
    chk(pw, 16'h5140);
    chk(fw, 16'h1E72);
    chk(rdata, 16'h0000);
    settle();
    chk(16'(st.sink_current_tenths_ma), 16'h0014);
    chk(16'(flags), 16'h007F);
    report_and_stop();
  end
endmodule // test_pll_loop_config_registers
`default_nettype wire
